// ---- design/slave_interpreter.sv ----
// slave-side message interpreter: frame check, register access and reply build
// Overview of operation
// - a read asks at most sixteen registers; more is refused with an error reply
// - read reply returns start register then following registers up to quantity
// - each register travels upper byte first, lower byte second
// - loop-back command is echoed unchanged as the normal reply
// - write words go to consecutive registers in ascending order
// - write byte count must equal twice the quantity and match the data
// - crc starts FFFFH, byte xored in, eight shifts with A001H feedback
// - crc covers address, function, data in link order
// - any slave address from 0 to 31 is answered; nothing configures it
// - reads and loop-backs are 8 bytes, writes 11 to 41 bytes
`timescale 1ns/1ps
`include "slave_map.svh"
module slave_interpreter (
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic              rx_valid_i,
  input  wire slave_pkg::byte_t  rx_data_i,
  input  wire logic              rx_end_i,
  input  wire logic              tx_ready_i,
  output logic                   tx_valid_o,
  output slave_pkg::byte_t       tx_data_o,
  output logic                   reg_rd_o,
  output logic                   reg_wr_o,
  output slave_pkg::word_t       reg_addr_o,
  output slave_pkg::word_t       reg_wdata_o,
  input  wire slave_pkg::word_t  reg_rdata_i,
  output logic                   busy_o
);
  import slave_pkg::*;

  state_t      state_reg,   state_next;
  byte_t       buf_reg  [0:40];
  byte_t       buf_next [0:40];
  logic [5:0]  cnt_reg,     cnt_next;
  logic        over_reg,    over_next;
  logic [5:0]  len_reg,     len_next;
  logic [5:0]  idx_reg,     idx_next;
  word_t       qty_reg,     qty_next;
  word_t       addr_reg,    addr_next;
  word_t       wdata_reg,   wdata_next;
  byte_t       txd_reg,     txd_next;

  crc_if crc_bus ();

  crc16_engine crc_unit (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .crc     (crc_bus.engine)
  );

  // byte position of data word i after a header of base bytes
  function automatic logic [5:0] word_pos(input logic [5:0] base, input logic [5:0] i);
    return 6'(base + (i << 1));
  endfunction : word_pos

  // decoded fields of the held command
  word_t fld_qty;
  byte_t fld_fn;
  logic  qty_ok;
  assign fld_fn  = buf_reg[`POS_FN];
  assign fld_qty = {buf_reg[`POS_QTY], buf_reg[6'(`POS_QTY + 6'h01)]};
  assign qty_ok  = (fld_qty != 16'h0000) && (fld_qty <= `MAX_REGS);

  // crc engine control: rx bytes while idle, tx data bytes while sending
  always_comb begin
    crc_bus.clear  = ((state_next == S_IDLE) && (state_reg != S_IDLE))
                   || ((state_next == S_SEND) && (state_reg != S_SEND)
                       && (state_reg != S_TAIL));
    crc_bus.enable = 1'b0;
    crc_bus.data   = rx_data_i;
    if (state_reg == S_IDLE) begin
      crc_bus.enable = rx_valid_i;
    end else if (state_reg == S_SEND) begin
      crc_bus.enable = tx_ready_i && (idx_reg < len_reg);
      crc_bus.data   = txd_reg;
    end
  end

  // message sequencer next values
  always_comb begin
    state_next = state_reg;
    buf_next   = buf_reg;
    cnt_next   = cnt_reg;
    over_next  = over_reg;
    len_next   = len_reg;
    idx_next   = idx_reg;
    qty_next   = qty_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    txd_next   = txd_reg;
    case (state_reg)
      S_IDLE: begin
        // collect bytes; frame end from the line-gap detector
        if (rx_valid_i) begin
          if (cnt_reg < `BUF_LEN) begin
            buf_next[cnt_reg] = rx_data_i;
            cnt_next          = 6'(cnt_reg + 6'h01);
          end else begin
            over_next = 1'b1;
          end
        end
        if (rx_end_i) begin
          state_next = S_CHECK;
        end
      end
      S_CHECK: begin
        cnt_next  = 6'h00;
        over_next = 1'b0;
        idx_next  = 6'h00;
        qty_next  = fld_qty;
        addr_next = {buf_reg[`POS_START], buf_reg[6'(`POS_START + 6'h01)]};
        wdata_next = {buf_reg[`POS_WDATA], buf_reg[6'(`POS_WDATA + 6'h01)]};
        txd_next  = buf_reg[`POS_ADDR];
        if (over_reg || (cnt_reg < `MIN_FRAME) || (crc_bus.value != 16'h0000)
            || (buf_reg[`POS_ADDR] > `ADDR_MAX)) begin
          state_next = S_IDLE;
        end else begin
          // default to an error reply, overridden by good commands
          state_next          = S_SEND;
          len_next            = `ERR_REPLY;
          buf_next[`POS_FN]   = fld_fn | `FN_ERR_FLAG;
          buf_next[`POS_CODE] = `ERR_DATA;
          case (fld_fn)
            `FN_READ: begin
              if ((cnt_reg == `READ_LEN) && qty_ok) begin
                state_next          = S_READ;
                buf_next[`POS_FN]   = fld_fn;
                buf_next[`POS_CODE] = byte_t'(fld_qty << 1);
              end
            end
            `FN_LOOP: begin
              if (cnt_reg == `LOOP_LEN) begin
                buf_next[`POS_FN]   = fld_fn;
                buf_next[`POS_CODE] = buf_reg[`POS_CODE];
                len_next            = `ECHO_REPLY;
              end
            end
            `FN_WRITE: begin
              if ((cnt_reg >= `WRITE_MIN) && qty_ok
                  && (buf_reg[`POS_COUNT] == byte_t'(fld_qty << 1))
                  && (cnt_reg == word_pos(6'(`POS_WDATA + 6'h02), fld_qty[5:0]))) begin
                state_next          = S_WRITE;
                buf_next[`POS_FN]   = fld_fn;
                buf_next[`POS_CODE] = buf_reg[`POS_CODE];
              end
            end
            default: begin
              buf_next[`POS_CODE] = `ERR_FUNC;
            end
          endcase
        end
      end
      S_READ: begin
        state_next = S_RCAP;
      end
      S_RCAP: begin
        // register word lands upper byte first
        buf_next[word_pos(`POS_RDATA, idx_reg)]                 = reg_rdata_i[15:8];
        buf_next[6'(word_pos(`POS_RDATA, idx_reg) + 6'h01)]     = reg_rdata_i[7:0];
        idx_next  = 6'(idx_reg + 6'h01);
        addr_next = 16'(addr_reg + 16'h0001);
        if (6'(idx_reg + 6'h01) == qty_reg[5:0]) begin
          state_next = S_SEND;
          idx_next   = 6'h00;
          len_next   = word_pos(`READ_HDR, qty_reg[5:0]);
        end else begin
          state_next = S_READ;
        end
      end
      S_WRITE: begin
        // one word per cycle, ascending addresses
        idx_next   = 6'(idx_reg + 6'h01);
        addr_next  = 16'(addr_reg + 16'h0001);
        wdata_next = {buf_reg[word_pos(6'(`POS_WDATA + 6'h02), idx_reg)],
                      buf_reg[6'(word_pos(6'(`POS_WDATA + 6'h02), idx_reg) + 6'h01)]};
        if (6'(idx_reg + 6'h01) == qty_reg[5:0]) begin
          state_next = S_SEND;
          idx_next   = 6'h00;
          len_next   = `ECHO_REPLY;
        end
      end
      S_SEND: begin
        if (tx_ready_i) begin
          idx_next = 6'(idx_reg + 6'h01);
          if (idx_reg < len_reg) begin
            if (6'(idx_reg + 6'h01) == len_reg) begin
              state_next = S_TAIL; // let the crc settle
            end else begin
              txd_next = buf_reg[6'(idx_reg + 6'h01)];
            end
          end else if (idx_reg == len_reg) begin
            txd_next = crc_bus.value[15:8];
          end else begin
            state_next = S_IDLE;
          end
        end
      end
      S_TAIL: begin
        txd_next   = crc_bus.value[7:0]; // low crc byte leaves first
        state_next = S_SEND;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      cnt_reg   <= 6'h00;
      over_reg  <= 1'b0;
      len_reg   <= 6'h00;
      idx_reg   <= 6'h00;
      qty_reg   <= 16'h0000;
      addr_reg  <= 16'h0000;
      wdata_reg <= 16'h0000;
      txd_reg   <= 8'h00;
      for (int k = 0; k < 41; k++) begin
        buf_reg[k] <= 8'h00;
      end
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      over_reg  <= over_next;
      len_reg   <= len_next;
      idx_reg   <= idx_next;
      qty_reg   <= qty_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      txd_reg   <= txd_next;
      buf_reg   <= buf_next;
    end
  end

  // port drive
  assign tx_valid_o  = (state_reg == S_SEND);
  assign tx_data_o   = txd_reg;
  assign reg_rd_o    = (state_reg == S_READ);
  assign reg_wr_o    = (state_reg == S_WRITE);
  assign reg_addr_o  = addr_reg;
  assign reg_wdata_o = wdata_reg;
  assign busy_o      = (state_reg != S_IDLE);

endmodule : slave_interpreter

// ---- design/slave_map.svh ----
// constants for the serial slave message interpreter
`ifndef SLAVE_MAP_SVH
`define SLAVE_MAP_SVH

// function codes and error reply marker
`define FN_READ      8'h03
`define FN_LOOP      8'h08
`define FN_WRITE     8'h10
`define FN_ERR_FLAG  8'h80

// error codes returned in an error reply
`define ERR_FUNC     8'h01
`define ERR_DATA     8'h03

// crc-16 start value and feedback constant
`define CRC_INIT     16'hFFFF
`define CRC_POLY     16'hA001

// message limits
`define MAX_REGS     16'h0010
`define ADDR_MAX     8'h1F
`define BUF_LEN      6'h29
`define READ_LEN     6'h08
`define LOOP_LEN     6'h08
`define WRITE_MIN    6'h0B
`define MIN_FRAME    6'h04

// byte positions inside a received or built message
`define POS_ADDR     6'h00
`define POS_FN       6'h01
`define POS_CODE     6'h02
`define POS_START    6'h02
`define POS_QTY      6'h04
`define POS_COUNT    6'h06
`define POS_WDATA    6'h07
`define POS_RDATA    6'h03

// reply lengths without the two crc bytes
`define ERR_REPLY    6'h03
`define ECHO_REPLY   6'h06
`define READ_HDR     6'h03

`endif

// ---- design/slave_pkg.sv ----
// types shared by the serial slave message interpreter
package slave_pkg;

  typedef logic [7:0]  byte_t;
  typedef logic [15:0] word_t;

  typedef enum {
    S_IDLE,
    S_CHECK,
    S_READ,
    S_RCAP,
    S_WRITE,
    S_SEND,
    S_TAIL
  } state_t;

endpackage : slave_pkg

// ---- design/crc_if.sv ----
// carrier between the interpreter and its crc engine
`timescale 1ns/1ps
interface crc_if;
  logic                clear;
  logic                enable;
  slave_pkg::byte_t    data;
  slave_pkg::word_t    value;

  modport engine (input clear, input enable, input data, output value);
  modport user   (output clear, output enable, output data, input value);
endinterface : crc_if

// ---- design/crc16_engine.sv ----
// byte-wide crc-16 accumulator
`timescale 1ns/1ps
`include "slave_map.svh"
module crc16_engine (
  input wire logic clock_i,
  input wire logic rst_i,
  crc_if.engine    crc
);
  import slave_pkg::*;

  word_t crc_reg;
  word_t crc_next;

  // one byte folded in, eight right shifts with feedback
  function automatic word_t crc_byte(input word_t seed, input byte_t value);
    word_t acc;
    acc = seed ^ {8'h00, value};
    for (int k = 0; k < 8; k++) begin
      if (acc[0]) begin
        acc = (acc >> 1) ^ `CRC_POLY;
      end else begin
        acc = acc >> 1;
      end
    end
    return acc;
  endfunction : crc_byte

  // clear has priority over a byte update
  always_comb begin
    crc_next = crc_reg;
    if (crc.clear) begin
      crc_next = `CRC_INIT;
    end else if (crc.enable) begin
      crc_next = crc_byte(crc_reg, crc.data);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      crc_reg <= `CRC_INIT;
    end else begin
      crc_reg <= crc_next;
    end
  end

  assign crc.value = crc_reg;

endmodule : crc16_engine

// ---- verification/reg_store_model.sv ----
// register store answering the interpreter's read and write strobes
`timescale 1ns/1ps
module reg_store_model (
  input  wire logic              clock_i,
  input  wire logic              rd_i,
  input  wire logic              wr_i,
  input  wire slave_pkg::word_t  addr_i,
  input  wire slave_pkg::word_t  wdata_i,
  output slave_pkg::word_t       rdata_o
);
  import slave_pkg::*;
  word_t mem [64];
  // read data stands one cycle, then toggles to its inverse each cycle, so a capture one cycle late never matches
  always @(posedge clock_i) begin
    if (wr_i) mem[addr_i[5:0]] <= wdata_i;
    rdata_o <= rd_i ? mem[addr_i[5:0]] : ~rdata_o;
  end
endmodule : reg_store_model

// ---- verification/slave_interpreter_assertions.sv ----
// port assertions for the slave message interpreter
`timescale 1ns/1ps
module slave_interpreter_checker (
  input wire logic              clock_i,
  input wire logic              rst_i,
  input wire logic              rx_valid_i,
  input wire slave_pkg::byte_t  rx_data_i,
  input wire logic              rx_end_i,
  input wire logic              tx_ready_i,
  input wire logic              tx_valid_o,
  input wire slave_pkg::byte_t  tx_data_o,
  input wire logic              reg_rd_o,
  input wire logic              reg_wr_o,
  input wire slave_pkg::word_t  reg_addr_o,
  input wire slave_pkg::word_t  reg_wdata_o,
  input wire slave_pkg::word_t  reg_rdata_i,
  input wire logic              busy_o
);
  import slave_pkg::*;
  logic [5:0] acc_reg;
  logic [5:0] acc_next;
  // register strobes counted within one frame
  always_comb begin
    acc_next = acc_reg;
    if (!busy_o) begin
      acc_next = 6'h00;
    end else if (reg_rd_o || reg_wr_o) begin
      acc_next = acc_reg + 6'h01;
    end
  end
  always_ff @(posedge clock_i) begin
    acc_reg <= rst_i ? 6'h00 : acc_next;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  chk_reset_quiet: assert property (disable iff (1'b0)
    rst_i |=> !tx_valid_o && !busy_o && !reg_rd_o && reg_addr_o == 16'h0000)
    else $error("outputs not cleared by reset");
  chk_frame_taken: assert property (rx_end_i && !busy_o |=> busy_o)
    else $error("frame end not taken");
  chk_rd_alternate: assert property (reg_rd_o |=> !reg_rd_o && !reg_wr_o)
    else $error("read strobes not spaced");
  chk_rd_next_addr: assert property (
    reg_rd_o ##2 reg_rd_o |-> reg_addr_o == $past(reg_addr_o, 2) + 16'h0001)
    else $error("read address not consecutive");
  chk_wr_next_addr: assert property (
    reg_wr_o ##1 reg_wr_o |-> reg_addr_o == $past(reg_addr_o) + 16'h0001)
    else $error("write address not ascending");
  chk_strobe_limit: assert property (acc_reg <= 6'h10)
    else $error("more than sixteen register accesses");
  chk_tx_hold: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("reply byte changed before taken");
  chk_idle_quiet: assert property (!busy_o |-> !tx_valid_o && !reg_rd_o && !reg_wr_o)
    else $error("activity while collecting");
  cover property (reg_wr_o ##1 reg_wr_o);
  cover property (tx_valid_o && !tx_ready_i);
  cover property (acc_reg == 6'h10);
endmodule : slave_interpreter_checker

bind slave_interpreter slave_interpreter_checker i_chk (
  .clock_i(clock_i), .rst_i(rst_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
  .rx_end_i(rx_end_i), .tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o),
  .tx_data_o(tx_data_o), .reg_rd_o(reg_rd_o), .reg_wr_o(reg_wr_o),
  .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o), .reg_rdata_i(reg_rdata_i),
  .busy_o(busy_o));

// ---- verification/tb_slave_interpreter.sv ----
// self-checking bench for the slave message interpreter
`timescale 1ns/1ps
module tb_slave_interpreter;
  import slave_pkg::*;
  typedef byte_t bq_t[$];
  typedef struct { logic [87:0] req; int rn; logic [47:0] rsp; int pn; } row_t;
  logic  clock_i;
  logic  rst_i = 1'b1;
  logic  rx_valid_i = 1'b0;
  byte_t rx_data_i = 8'h00;
  logic  rx_end_i = 1'b0;
  logic  tx_ready_i = 1'b1;
  logic  tx_valid_o, reg_rd_o, reg_wr_o, busy_o;
  byte_t tx_data_o;
  word_t reg_addr_o, reg_wdata_o, reg_rdata_i;
  int    error_cnt = 0;
  int    n_tests = 0;
  bq_t   e, w, r;
  // requests beside the replies they should give, crc added by the bench
  row_t rows[8] = '{
    '{88'h01_08_00_00_A5_37, 6, 48'h01_08_00_00_A5_37, 6},
    '{88'h1F_08_12_34_56_78, 6, 48'h1F_08_12_34_56_78, 6},
    '{88'h02_03_00_20_00_11, 6, 48'h02_83_03, 3},
    '{88'h02_03_00_20_00_00, 6, 48'h02_83_03, 3},
    '{88'h02_03_00_20_00, 5, 48'h02_83_03, 3},
    '{88'h02_05_00_00_00_01, 6, 48'h02_85_01, 3},
    '{88'h01_10_00_01_00_02_03_00_01_02_58, 11, 48'h01_90_03, 3},
    '{88'h01_10_00_01_00_02_04_00_01_02_58, 11, 48'h01_10_00_01_00_02, 6}};

  slave_interpreter i_dut (.clock_i(clock_i), .rst_i(rst_i), .rx_valid_i(rx_valid_i),
    .rx_data_i(rx_data_i), .rx_end_i(rx_end_i), .tx_ready_i(tx_ready_i),
    .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .reg_rd_o(reg_rd_o),
    .reg_wr_o(reg_wr_o), .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o),
    .reg_rdata_i(reg_rdata_i), .busy_o(busy_o));
  reg_store_model i_store (.clock_i(clock_i), .rd_i(reg_rd_o), .wr_i(reg_wr_o),
    .addr_i(reg_addr_o), .wdata_i(reg_wdata_o), .rdata_o(reg_rdata_i));

  // 50 ns clock
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // reference crc, low byte sent first
  function automatic logic [15:0] crc16(input bq_t q);
    logic [15:0] c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction : crc16

  function automatic bq_t to_q(input logic [87:0] v, input int n);
    bq_t q;
    for (int i = n - 1; i >= 0; i--) q.push_back(v[8*i +: 8]);
    return q;
  endfunction : to_q

  // one frame in, whole reply out, compared byte by byte
  task automatic xfer(input bq_t req, input bq_t exp, input bit stall, input bit bad,
                      input string name);
    logic [15:0] c;
    bq_t got;
    int k;
    c = crc16(req) ^ {16{bad}};
    req.push_back(c[7:0]);
    req.push_back(c[15:8]);
    foreach (req[i]) begin
      @(posedge clock_i);
      #5;
      rx_valid_i = 1'b1;
      rx_data_i = req[i];
      rx_end_i = (i == req.size() - 1);
    end
    @(posedge clock_i);
    #5;
    rx_valid_i = 1'b0;
    rx_end_i = 1'b0;
    for (k = 0; k < 600 && !(k > 3 && busy_o === 1'b0); k++) begin
      tx_ready_i = !stall || k[0];
      @(negedge clock_i);
      if (tx_valid_o === 1'b1 && tx_ready_i) got.push_back(tx_data_o);
      @(posedge clock_i);
      #5;
    end
    tx_ready_i = 1'b1;
    if (k == 600) begin
      check(16'(k), 16'h0000, "reply wait");
      wrap_up();
    end
    if (exp.size() > 0) begin
      c = crc16(exp);
      exp.push_back(c[7:0]);
      exp.push_back(c[15:8]);
    end
    check(16'(got.size()), 16'(exp.size()), "reply length");
    foreach (exp[i]) if (i < got.size()) check(16'(got[i]), 16'(exp[i]), "reply byte");
    $display("test %s done", name);
  endtask : xfer

  initial begin
    repeat (10) @(posedge clock_i);
    #5;
    check(16'({tx_valid_o, busy_o, reg_rd_o, reg_wr_o}), 16'h0000, "reset flags");
    check(reg_addr_o | reg_wdata_o | 16'(tx_data_o), 16'h0000, "reset data");
    check(crc16(to_q(24'h02_83_03, 3)), 16'h31F1, "crc anchor");
    rst_i = 1'b0;
    foreach (rows[i]) xfer(to_q(rows[i].req, rows[i].rn), to_q(rows[i].rsp, rows[i].pn),
                           1'b0, 1'b0, "table row");
    xfer(to_q(48'h20_08_00_00_A5_37, 6), e, 1'b0, 1'b0, "address 32");
    xfer(to_q(48'h01_08_00_00_A5_37, 6), e, 1'b0, 1'b1, "bad crc");
    // sixteen-word write, then read back through a stalling sink
    w = to_q(56'h01_10_00_30_00_10_20, 7);
    r = to_q(24'h01_03_20, 3);
    for (int i = 0; i < 16; i++) begin
      w.push_back(8'hA5 ^ 8'(i));
      w.push_back(8'(3 * i));
      r.push_back(8'hA5 ^ 8'(i));
      r.push_back(8'(3 * i));
    end
    xfer(w, to_q(48'h01_10_00_30_00_10, 6), 1'b0, 1'b0, "write 16");
    xfer(to_q(48'h01_03_00_30_00_10, 6), r, 1'b1, 1'b0, "read 16");
    // one byte beyond the longest frame, and a frame too short to hold a function code
    w.push_back(8'h00);
    xfer(w, e, 1'b0, 1'b0, "overrun");
    xfer(to_q(8'h01, 1), e, 1'b0, 1'b0, "short frame");
    // reset in mid-frame, then a clean frame must still pass
    @(posedge clock_i);
    #5;
    rx_valid_i = 1'b1;
    rx_data_i = 8'h01;
    @(posedge clock_i);
    #5;
    rx_valid_i = 1'b0;
    rst_i = 1'b1;
    @(posedge clock_i);
    #5;
    rst_i = 1'b0;
    xfer(to_q(rows[0].req, 6), to_q(rows[0].rsp, 6), 1'b0, 1'b0, "after reset");
    wrap_up();
  end
endmodule : tb_slave_interpreter
